/* File: cor_pkg.sv */
// Purpose: Constants for the comparator output routing block.
// Assumes: 50 MHz clock, byte-addressed register port.
// Notes: Offsets are byte addresses on the plain register port.
// Notes on behaviour
// RQ1: Bit 18 set inverts the filtered result driven to the pad.
// RQ2: Bit 17 set forwards the comparator event as advanced timer brake.
// RQ3: Channel 4 gate follows result while enabled, inverted by bit 15.
// RQ4: Channel 3 gate enabled by bit 14, inverted by bit 13.
// RQ5: Channel 2 gate enabled by bit 12, inverted by bit 11.
// RQ6: Channel 1 gate enabled by bit 10, inverted by bit 9.
// RQ7: Bit 8 routes result to timer array external clock.
// RQ8: Bit 7 routes result to timer array capture channel 0.
// RQ9: Bit 6 inverts result on both timer array paths.
// RQ10: Bit 5 routes result to low-power timer external clock.
// RQ11: Bit 4 routes result to low-power timer gate.
// RQ12: Bit 2 routes result to second basic timer gate; bit 3 reserved.
// RQ13: Bit 1 routes result to first basic timer gate.
// RQ14: Bit 0 inverts gates of both basic timers and low-power timer.
// RQ15: Status bit 1 reads live filtered level; writes ignored.
// RQ16: Status bit 0 flag holds until written zero; one has no effect.
// RQ17: Filter suppresses pulses shorter than 16-bit count; bypass when off.
// RQ18: Flag set on high level, rising or falling edge per enable.
// RQ19: Gate, clock and capture paths are enable-gated copies; disabled paths drive low.
package cor_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_ROUTE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam int CTRL_FILTER_COUNT_LSB = 16;
   localparam int CTRL_HIGH_EN = 14;
   localparam int CTRL_RISE_EN = 13;
   localparam int CTRL_FALL_EN = 12;
   localparam int CTRL_FLT_EN = 8;
   localparam int RT_PAD_INV = 18;
   localparam int RT_BRAKE_EN = 17;
   localparam int RT_CH4_EN = 16;
   localparam int RT_CH4_INV = 15;
   localparam int RT_CH3_EN = 14;
   localparam int RT_CH3_INV = 13;
   localparam int RT_CH2_EN = 12;
   localparam int RT_CH2_INV = 11;
   localparam int RT_CH1_EN = 10;
   localparam int RT_CH1_INV = 9;
   localparam int RT_ARR_CLK_EN = 8;
   localparam int RT_ARR_CAP_EN = 7;
   localparam int RT_ARR_INV = 6;
   localparam int RT_LPT_CLK_EN = 5;
   localparam int RT_LPT_GATE_EN = 4;
   localparam int RT_BTB_EN = 2;
   localparam int RT_BTA_EN = 1;
   localparam int RT_BT_INV = 0;
   localparam int ST_FLAG = 0;
   localparam int ST_LEVEL = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
   localparam logic [31:0] ROUTE_WMASK = 32'h0007_fff7;
   localparam logic [31:0] CTRL_WMASK = 32'hffff_7100;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
endpackage

/* File: cor_filter.sv */
// Purpose: Digital glitch filter for the raw comparator result.
// Assumes: Raw input is synchronous to the clock.
// Notes: Output changes only after the input holds for the count.
`timescale 1ns/1ps
module cor_filter
   import cor_pkg::*;
(
   input wire logic clk_i,              // Clock.
   input wire logic rstn_i,             // Synchronous reset, active low.
   input wire logic enable_i,           // Filter enable.
   input wire logic [15:0] count_i,     // Filter count.
   input wire logic raw_i,              // Raw comparator result.
   output logic level_o                 // Filtered level.
);
   logic held;
   logic [15:0] run;
   wire differs = (raw_i != held);
   wire settled = (run >= count_i);

   // Pulses shorter than the count never reach the output. [RQ17]
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         held <= 1'b0;
         run <= 16'h0000;
      end else if (!enable_i) begin
         held <= raw_i;
         run <= 16'h0000;
      end else if (!differs) begin
         run <= 16'h0000;
      end else if (settled) begin
         held <= raw_i;
         run <= 16'h0000;
      end else begin
         run <= run + 16'h0001;
      end
   end

   // Bypass when disabled keeps output equal to input. [RQ17]
   assign level_o = enable_i ? held : raw_i;
endmodule

/* File: cor_top.sv */
// Purpose: Comparator filter, event flag and output routing.
// Assumes: Register port is word aligned; all inputs synchronous.
// Notes: Every output is registered, so routes lag the level by one cycle.
`timescale 1ns/1ps
module cor_top
   import cor_pkg::*;
(
   input wire logic MCLK_I,             // 50 MHz clock.
   input wire logic RSTN_I,             // Synchronous reset, active low.
   input wire logic CMP_RAW_I,          // Raw comparator result.
   input wire logic [7:0] ADDR_I,       // Register byte address.
   input wire logic [31:0] WDATA_I,     // Write data.
   input wire logic WR_I,               // Write strobe.
   input wire logic RD_I,               // Read strobe.
   output logic [31:0] RDATA_O,         // Read data, cycle after strobe.
   output logic IRQ_O,                  // Level interrupt.
   output logic PAD_O,                  // Result to pad.
   output logic BRAKE_O,                // Brake request, advanced timer.
   output logic [3:0] ADV_GATE_O,       // Channel gates 1..4.
   output logic ARR_CLK_O,              // Timer array external clock.
   output logic ARR_CAP0_O,             // Timer array capture 0.
   output logic LPT_CLK_O,              // Low-power timer clock.
   output logic LPT_GATE_O,             // Low-power timer gate.
   output logic BTA_GATE_O,             // First basic timer gate.
   output logic BTB_GATE_O              // Second basic timer gate.
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] route;
   logic irq_flag;
   logic irq_mask;
   logic level_q;
   logic level;

   wire sel_ctrl = (ADDR_I == OFS_CTRL);
   wire sel_route = (ADDR_I == OFS_ROUTE);
   wire sel_status = (ADDR_I == OFS_STATUS);
   wire sel_mask = (ADDR_I == OFS_MASK);
   wire wr_status = WR_I && sel_status;

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         ctrl <= CTRL_RESET;
         route <= ROUTE_RESET;
         irq_mask <= MASK_RESET[0];
      end else if (WR_I) begin
         if (sel_ctrl) begin
            ctrl <= WDATA_I & CTRL_WMASK;
         end
         // Reserved bit 3 never stores, so it has no effect. [RQ12]
         if (sel_route) begin
            route <= WDATA_I & ROUTE_WMASK;
         end
         if (sel_mask) begin
            irq_mask <= WDATA_I[0];
         end
      end
   end

   // ------------------------------------------------------------
   // Filter and events
   // ------------------------------------------------------------
   cor_filter u_filter (
      .clk_i(MCLK_I),
      .rstn_i(RSTN_I),
      .enable_i(ctrl[CTRL_FLT_EN]),
      .count_i(ctrl[CTRL_FILTER_COUNT_LSB +: 16]),
      .raw_i(CMP_RAW_I),
      .level_o(level)
   );

   wire rise = level && !level_q;
   wire fall = !level && level_q;
   wire event_hit = (ctrl[CTRL_HIGH_EN] && level) ||
      (ctrl[CTRL_RISE_EN] && rise) ||
      (ctrl[CTRL_FALL_EN] && fall);                       // [RQ18]
   wire clear_flag = wr_status && !WDATA_I[ST_FLAG];

   // Set wins over a clear in the same cycle. [RQ16]
   wire next_flag = event_hit ? 1'b1 : (clear_flag ? 1'b0 : irq_flag);

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         level_q <= 1'b0;
         irq_flag <= 1'b0;
      end else begin
         level_q <= level;
         irq_flag <= next_flag;                           // [RQ16]
      end
   end

   // ------------------------------------------------------------
   // Routing
   // ------------------------------------------------------------
   wire arr_lvl = level ^ route[RT_ARR_INV];              // [RQ9]
   wire bt_lvl = level ^ route[RT_BT_INV];                // [RQ14]
   logic [3:0] gate_en;
   logic [3:0] gate_inv;
   logic [3:0] next_gate;

   assign gate_en = {route[RT_CH4_EN], route[RT_CH3_EN],
                     route[RT_CH2_EN], route[RT_CH1_EN]};
   assign gate_inv = {route[RT_CH4_INV], route[RT_CH3_INV],
                      route[RT_CH2_INV], route[RT_CH1_INV]};

   // Each channel gate is an enabled copy with its own polarity. [RQ19]
   for (genvar g = 0; g < 4; g++) begin : g_gate
      assign next_gate[g] = gate_en[g] & (level ^ gate_inv[g]); // [RQ3]
   end

   wire [31:0] status_word = {30'h0, level, irq_flag};    // [RQ15]
   wire [31:0] read_mux = sel_ctrl ? ctrl :
                          sel_route ? route :
                          sel_status ? status_word :
                          sel_mask ? {31'h0, irq_mask} : 32'h0;

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         RDATA_O <= 32'h0;
         IRQ_O <= 1'b0;
         PAD_O <= 1'b0;
         BRAKE_O <= 1'b0;
         ADV_GATE_O <= 4'h0;
         ARR_CLK_O <= 1'b0;
         ARR_CAP0_O <= 1'b0;
         LPT_CLK_O <= 1'b0;
         LPT_GATE_O <= 1'b0;
         BTA_GATE_O <= 1'b0;
         BTB_GATE_O <= 1'b0;
      end else begin
         RDATA_O <= RD_I ? read_mux : 32'h0;
         IRQ_O <= next_flag && irq_mask;
         PAD_O <= level ^ route[RT_PAD_INV];              // [RQ1]
         BRAKE_O <= route[RT_BRAKE_EN] && event_hit;      // [RQ2]
         ADV_GATE_O <= next_gate;                  // [RQ3] [RQ4] [RQ5] [RQ6]
         ARR_CLK_O <= route[RT_ARR_CLK_EN] && arr_lvl;    // [RQ7]
         ARR_CAP0_O <= route[RT_ARR_CAP_EN] && arr_lvl;   // [RQ8]
         LPT_CLK_O <= route[RT_LPT_CLK_EN] && level;      // [RQ10]
         LPT_GATE_O <= route[RT_LPT_GATE_EN] && bt_lvl;   // [RQ11]
         BTA_GATE_O <= route[RT_BTA_EN] && bt_lvl;        // [RQ13]
         BTB_GATE_O <= route[RT_BTB_EN] && bt_lvl;        // [RQ12]
      end
   end
endmodule

/* File: cor_top_asserts.sv */
// Purpose: Port assertions for cor_top.
// Assumes: Checks other than chk_brake_off pause while the filter is on; else level is raw input.
// Notes: Route and filter enable are shadowed from writes.
`timescale 1ns/1ps
module cor_chk
   import cor_pkg::*;
(
   input wire logic MCLK_I, // Clock.
   input wire logic RSTN_I, // Reset.
   input wire logic CMP_RAW_I, // Raw.
   input wire logic [7:0] ADDR_I, // Address.
   input wire logic [31:0] WDATA_I, // Data.
   input wire logic WR_I, // Write.
   input wire logic PAD_O, // Pad.
   input wire logic BRAKE_O, // Brake.
   input wire logic [3:0] ADV_GATE_O, // Gates.
   input wire logic ARR_CLK_O, // Array clock.
   input wire logic ARR_CAP0_O, // Capture.
   input wire logic LPT_CLK_O, // Lp clock.
   input wire logic LPT_GATE_O, // Lp gate.
   input wire logic BTA_GATE_O, // Timer a.
   input wire logic BTB_GATE_O // Timer b.
);
   logic [31:0] rt, q;
   logic v, ok, fe;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         {rt, q, v, ok, fe} <= '0;
      end else begin
         q <= rt;
         v <= CMP_RAW_I;
         ok <= !fe;
         if (WR_I && ADDR_I == OFS_ROUTE) rt <= WDATA_I & ROUTE_WMASK;
         if (WR_I && ADDR_I == OFS_CTRL) fe <= WDATA_I[CTRL_FLT_EN];
      end
   end
   chk_pad_level: assert property (ok |-> PAD_O == (v ^ q[18]))
      else $error("pad level wrong");
   chk_brake_off: assert property (!q[17] |-> !BRAKE_O)
      else $error("brake without enable");
   chk_ch4_gate: assert property (ok |-> ADV_GATE_O[3] ==
      (q[16] & (v ^ q[15]))) else $error("ch4 gate wrong");
   chk_ch3_gate: assert property (ok |-> ADV_GATE_O[2] ==
      (q[14] & (v ^ q[13]))) else $error("ch3 gate wrong");
   chk_ch12_gates: assert property (ok |-> ADV_GATE_O[1:0] ==
      {q[12] & (v ^ q[11]), q[10] & (v ^ q[9])}) else $error("ch gate");
   chk_array_paths: assert property (ok |->
      {ARR_CLK_O, ARR_CAP0_O} == ({q[8], q[7]} & {2{v ^ q[6]}}))
      else $error("array path wrong");
   chk_lpt_paths: assert property (ok |->
      {LPT_CLK_O, LPT_GATE_O} == {q[5] & v, q[4] & (v ^ q[0])})
      else $error("low-power path wrong");
   chk_basic_gates: assert property (ok |->
      {BTB_GATE_O, BTA_GATE_O} == ({q[2], q[1]} & {2{v ^ q[0]}}))
      else $error("basic gate wrong");
endmodule
bind cor_top cor_chk u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .CMP_RAW_I(CMP_RAW_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
   .PAD_O(PAD_O), .BRAKE_O(BRAKE_O), .ADV_GATE_O(ADV_GATE_O),
   .ARR_CLK_O(ARR_CLK_O), .ARR_CAP0_O(ARR_CAP0_O), .LPT_CLK_O(LPT_CLK_O),
   .LPT_GATE_O(LPT_GATE_O), .BTA_GATE_O(BTA_GATE_O),
   .BTB_GATE_O(BTB_GATE_O));

/* File: cor_far.sv */
// Purpose: Far-side model of the timer array and brake inputs.
// Assumes: The far side samples on the same clock.
// Notes: Counts rising array clock edges and latches any brake.
`timescale 1ns/1ps
module cor_far (
   input wire logic clk_i, // Clock.
   input wire logic rstn_i, // Reset, active low.
   input wire logic arr_clk_i, // Array clock.
   input wire logic brake_i, // Brake request.
   output logic [7:0] ticks_o, // Edges seen.
   output logic brake_o // Brake latched.
);
   logic prev;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         {ticks_o, brake_o, prev} <= '0;
      end else begin
         prev <= arr_clk_i;
         ticks_o <= ticks_o + {7'h0, arr_clk_i & ~prev};
         brake_o <= brake_o | brake_i;
      end
   end
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for cor_top.
// Assumes: Filter is off outside its own test and the all-ones control write, so routes follow the input.
// Notes: Rows cover routing; events and status are hand tests.
`timescale 1ns/1ps
module tb_top
   import cor_pkg::*;
;
   typedef struct packed {
      logic [31:0] rt;
      logic raw;
      logic [10:0] ex;
   } cor_row_t;
   cor_row_t rows [8] = '{'{32'h0, 1'h1, 11'h400},
      '{32'h40000, 1'h1, 11'h0}, '{32'h1, 1'h0, 11'h0},
      '{32'h155b6, 1'h1, 11'h7ff}, '{32'h155b6, 1'h0, 11'h0},
      '{32'h7fff7, 1'h1, 11'h8}, '{32'h7fff7, 1'h0, 11'h7f7},
      '{32'h8, 1'h1, 11'h400}};
   logic MCLK_I, RSTN_I = 1'h0, CMP_RAW_I = 1'h0, WR_I = 1'h0, RD_I = 1'h0;
   logic [7:0] ADDR_I = 8'h0;
   logic [31:0] WDATA_I = 32'h0, RDATA_O, outs;
   logic IRQ_O, PAD_O, BRAKE_O, ARR_CLK_O, ARR_CAP0_O, LPT_CLK_O;
   logic LPT_GATE_O, BTA_GATE_O, BTB_GATE_O, brk;
   logic [3:0] ADV_GATE_O;
   logic [7:0] ticks, t0;
   int n_errors = 0, n_checks = 0;
   assign outs = {21'h0, PAD_O, ADV_GATE_O, ARR_CLK_O, ARR_CAP0_O,
      LPT_CLK_O, LPT_GATE_O, BTA_GATE_O, BTB_GATE_O};
   cor_top dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .CMP_RAW_I(CMP_RAW_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
      .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .PAD_O(PAD_O), .BRAKE_O(BRAKE_O),
      .ADV_GATE_O(ADV_GATE_O), .ARR_CLK_O(ARR_CLK_O),
      .ARR_CAP0_O(ARR_CAP0_O), .LPT_CLK_O(LPT_CLK_O),
      .LPT_GATE_O(LPT_GATE_O), .BTA_GATE_O(BTA_GATE_O),
      .BTB_GATE_O(BTB_GATE_O));
   cor_far far (.clk_i(MCLK_I), .rstn_i(RSTN_I), .arr_clk_i(ARR_CLK_O),
      .brake_i(BRAKE_O), .ticks_o(ticks), .brake_o(brk));
   initial begin
      MCLK_I = 1'h0;
      forever #10 MCLK_I = ~MCLK_I;
   end
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'h1;
      @(posedge MCLK_I);
      WR_I <= 1'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge MCLK_I);
      ADDR_I <= a;
      RD_I <= 1'h1;
      @(posedge MCLK_I);
      RD_I <= 1'h0;
      #1 chk(RDATA_O, e);
   endtask
   task automatic sr(input logic b, input int n);
      @(posedge MCLK_I);
      CMP_RAW_I <= b;
      repeat (n) @(posedge MCLK_I);
      #1;
   endtask
   initial begin
      #100000;
      n_errors++;
      test_done;
   end
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge MCLK_I);
      RSTN_I <= 1'h1;
      #1 chk({IRQ_O, BRAKE_O, outs[29:0]}, 32'h0);
      rdc(OFS_ROUTE, ROUTE_RESET);
      rdc(OFS_STATUS, 32'h0);
      foreach (rows[i]) begin
         wr(OFS_ROUTE, rows[i].rt);
         sr(rows[i].raw, 2);
         chk(outs, {21'h0, rows[i].ex});
         rdc(OFS_ROUTE, rows[i].rt & ROUTE_WMASK);
      end
      wr(OFS_MASK, 32'h1);
      for (int m = 0; m < 3; m++) begin
         wr(OFS_CTRL, 32'h4000 >> m);
         sr(1'h0, 3);
         wr(OFS_STATUS, 32'h0);
         sr(1'h0, 2);
         chk(IRQ_O, 0);
         sr(1'h1, 3);
         chk(IRQ_O, m < 2);
         sr(1'h0, 3);
         chk(IRQ_O, 1);
      end
      chk(brk, 0);
      wr(OFS_ROUTE, 32'h20100);
      t0 = ticks;
      for (int k = 0; k < 3; k++) begin
         sr(1'h1, 2);
         sr(1'h0, 2);
      end
      chk(ticks - t0, 3);
      chk(brk, 1);
      sr(1'h1, 2);
      rdc(OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'h3);
      rdc(OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'h0);
      rdc(OFS_STATUS, 32'h2);
      chk(IRQ_O, 0);
      wr(OFS_MASK, 32'h0);
      sr(1'h0, 3);
      chk(IRQ_O, 0);
      rdc(OFS_STATUS, 32'h1);
      wr(OFS_ROUTE, 32'hffff_ffff);
      rdc(OFS_ROUTE, 32'h0007_fff7);
      wr(OFS_CTRL, 32'hffff_ffff);
      rdc(OFS_CTRL, 32'hffff_7100);
      // A two-cycle pulse must die in the filter, a four-cycle one pass.
      wr(OFS_CTRL, 32'h0003_2100);
      wr(OFS_STATUS, 32'h0);
      sr(1'h1, 1);
      sr(1'h0, 2);
      rdc(OFS_STATUS, 32'h0);
      sr(1'h1, 4);
      rdc(OFS_STATUS, 32'h3);
      // A clear that meets a high-level event leaves the flag set.
      wr(OFS_CTRL, 32'h4000);
      wr(OFS_STATUS, 32'h0);
      rdc(OFS_STATUS, 32'h3);
      @(posedge MCLK_I);
      #1 chk(RDATA_O, 32'h0);
      @(posedge MCLK_I);
      RSTN_I <= 1'h0;
      repeat (2) @(posedge MCLK_I);
      RSTN_I <= 1'h1;
      #1 chk({IRQ_O, BRAKE_O, outs[29:0]}, 32'h0);
      rdc(OFS_ROUTE, ROUTE_RESET);
      rdc(OFS_STATUS, 32'h2);
      rdc(8'h20, 32'h0);
      test_done;
   end
endmodule
